/* File: rtl/adcsp_pkg.sv */
package adcsp_pkg;
  // Frame shape, counted in serial clock cycles and edges
  localparam int TRACK_CYCLES   = 3;
  localparam int CONV_CYCLES    = 13;
  localparam int FRAME_CYCLES   = TRACK_CYCLES + CONV_CYCLES;
  localparam int HOLD_EDGE      = TRACK_CYCLES + 1;
  localparam int RESULT_FIRST   = 5;
  localparam int RESULT_LAST    = 14;
  localparam int RESULT_W       = RESULT_LAST - RESULT_FIRST + 1;
  // Control byte, shifted in MSB first on the first rising edges
  localparam int CTRL_BITS        = 8;
  localparam int CHAN_W           = 3;
  localparam int CHANNEL_SEL_BIT2 = 5;
  localparam int CHANNEL_SEL_BIT1 = 4;
  localparam int CHANNEL_SEL_BIT0 = 3;
  localparam logic [3:0] SEL2_RISE = 4'(CTRL_BITS - 1 - CHANNEL_SEL_BIT2);
  localparam logic [3:0] SEL1_RISE = 4'(CTRL_BITS - 1 - CHANNEL_SEL_BIT1);
  localparam logic [3:0] SEL0_RISE = 4'(CTRL_BITS - 1 - CHANNEL_SEL_BIT0);
  localparam logic [3:0] CTRL_LAST_RISE = 4'(CTRL_BITS - 1);
  // Power-up channel is analog_input_0
  localparam logic [CHAN_W-1:0] CHAN_RESET = 3'h0;
  // Result buffer between the converter and the link
  localparam int FIFO_WORDS = 4;
endpackage

/* File: rtl/adcsp_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module adcsp_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
    $error("adcsp_fifo needs DEPTH >= 2 and WIDTH >= 1");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [CW-1:0]    count_q;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count
  assign in_ready  = (count_q != CW'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;

  // One storage word per entry, written when the write pointer lands on it
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (reset) begin
        mem_q[i] <= '0;
      end else if (push && wr_ptr_q == PW'(i)) begin
        mem_q[i] <= in_data;
      end
    end
  end

  // Pointers wrap at DEPTH, so any depth of two or more works, not only powers of two
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + PW'(1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + PW'(1);
      end
    end
  end

  // Occupancy
  always_ff @(posedge clk) begin
    if (reset) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= count_q + CW'(1);
    end else if (pop && !push) begin
      count_q <= count_q - CW'(1);
    end
  end
endmodule
`default_nettype wire

/* File: rtl/adcsp_port.sv */
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Each conversion tracks the selected input for exactly three serial clock cycles.
// - After holding, conversion occupies exactly thirteen serial clock cycles.
// - Tracking ends and hold begins on the fourth falling clock edge.
// - Frame select falling turns the data output driver on.
// - Frame select rising returns the data output to high impedance.
// - Each output bit changes only after a falling clock edge.
// - Control input is sampled on rising clock edges.
// - First eight rising edges carry a control byte; bits 5..3 pick next channel.
// - Output is four zeros, ten result bits MSB first, then two zeros.
// - After power-up the first conversion uses channel zero.
module adcsp_port
  import adcsp_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_WORDS
) (
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire logic                core_ce,
  input  wire logic                sclk,
  input  wire logic                cs_n,
  input  wire logic                sdi,
  output logic                     sdo_out,
  output logic                     sdo_oe,
  output logic                     conv_start,
  output logic      [CHAN_W-1:0]   conv_channel,
  input  wire logic                conv_valid,
  input  wire logic [RESULT_W-1:0] conv_data,
  output logic                     conv_ready
);
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("adcsp_port needs FIFO_DEPTH >= 2");
  end

  typedef enum logic {XF_IDLE, XF_WAIT} adcsp_xfer_t;

  // Link side state
  logic [3:0]          rise_cnt_q;
  logic [4:0]          fall_idx;
  logic [CHAN_W-1:0]   channel_sel_q;
  logic [CHAN_W-1:0]   channel_q;
  logic                hold_q;
  logic [3:0]          hold_len_q;
  logic [RESULT_W-1:0] out_word_q;
  logic                sdo_q;
  logic                sdo_rise_q;
  logic                req_tgl_q;
  logic [CHAN_W-1:0]   req_ch_q;
  logic                xf_s1_q;
  logic                xf_s2_q;
  logic                xf_s3_q;
  logic [RESULT_W-1:0] result_q;
  // Core side state
  logic                rst_link_q;
  logic                rq_s1_q;
  logic                rq_s2_q;
  logic                rq_s3_q;
  logic                start_q;
  logic [CHAN_W-1:0]   start_ch_q;
  logic                ack_s1_q;
  logic                ack_s2_q;
  adcsp_xfer_t         xf_state_q;
  logic                xfer_tgl_q;
  logic [RESULT_W-1:0] xfer_data_q;
  logic                fifo_valid;
  logic                fifo_pop;
  logic [RESULT_W-1:0] fifo_data;

  // Falling edge k of a conversion follows k-1 rising edges; a frame that opens with
  // the clock low treats the select fall as edge 1, which this numbering gives for free
  assign fall_idx = {1'b0, rise_cnt_q} + 5'h01;

  // Driver follows frame select directly; no clock runs outside a frame
  assign sdo_oe     = !cs_n;
  assign sdo_out    = sdo_q;
  assign conv_start   = start_q;
  assign conv_channel = start_ch_q;

  // Core reset registered once, then used as the link side's power-up reset
  always_ff @(posedge core_clk) begin
    rst_link_q <= reset;
  end

  // Rising-edge count; wraps every sixteen edges for back-to-back conversions
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rise_cnt_q <= 4'h0;
    end else begin
      rise_cnt_q <= rise_cnt_q + 4'h1;
    end
  end

  // Control byte: pick the select bits off the rising edges, commit after the eighth
  always_ff @(posedge sclk or posedge rst_link_q) begin
    if (rst_link_q) begin
      channel_sel_q <= CHAN_RESET;
      channel_q     <= CHAN_RESET;
    end else if (!cs_n) begin
      if (rise_cnt_q == SEL2_RISE) begin
        channel_sel_q[2] <= sdi;
      end
      if (rise_cnt_q == SEL1_RISE) begin
        channel_sel_q[1] <= sdi;
      end
      if (rise_cnt_q == SEL0_RISE) begin
        channel_sel_q[0] <= sdi;
      end
      if (rise_cnt_q == CTRL_LAST_RISE) begin
        channel_q <= channel_sel_q;
      end
    end
  end

  // Track/hold phase and the hold-length counter that the checks read
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      hold_q     <= 1'b0;
      hold_len_q <= 4'h0;
    end else begin
      if (fall_idx == 5'(HOLD_EDGE)) begin
        hold_q     <= 1'b1;
        hold_len_q <= 4'h0;
      end else begin
        if (fall_idx == 5'h01) begin
          hold_q <= 1'b0;
        end
        if (hold_q) begin
          hold_len_q <= hold_len_q + 4'h1;
        end
      end
    end
  end

  // Output shifter: result snapshot taken at hold so a late update cannot tear a word
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      sdo_q      <= 1'b0;
      out_word_q <= '0;
    end else begin
      if (fall_idx == 5'(HOLD_EDGE)) begin
        out_word_q <= result_q;
      end
      if (fall_idx >= 5'(RESULT_FIRST) && fall_idx <= 5'(RESULT_LAST)) begin
        sdo_q <= out_word_q[4'(5'(RESULT_LAST) - fall_idx)];
      end else begin
        sdo_q <= 1'b0;
      end
    end
  end

  // Conversion request toggles at hold; channel travels with it and stays put until the next hold
  always_ff @(negedge sclk or posedge rst_link_q) begin
    if (rst_link_q) begin
      req_tgl_q <= 1'b0;
      req_ch_q  <= CHAN_RESET;
    end else if (!cs_n && fall_idx == 5'(HOLD_EDGE)) begin
      req_tgl_q <= !req_tgl_q;
      req_ch_q  <= channel_q;
    end
  end

  // Result word arrives by toggle handshake; the third stage doubles as the acknowledge
  always_ff @(posedge sclk or posedge rst_link_q) begin
    if (rst_link_q) begin
      xf_s1_q  <= 1'b0;
      xf_s2_q  <= 1'b0;
      xf_s3_q  <= 1'b0;
      result_q <= '0;
    end else begin
      xf_s1_q <= xfer_tgl_q;
      xf_s2_q <= xf_s1_q;
      xf_s3_q <= xf_s2_q;
      if (xf_s2_q != xf_s3_q) begin
        result_q <= xfer_data_q;
      end
    end
  end

  // Request crossing into the core clock and the converter start pulse
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rq_s1_q    <= 1'b0;
      rq_s2_q    <= 1'b0;
      rq_s3_q    <= 1'b0;
      start_q    <= 1'b0;
      start_ch_q <= CHAN_RESET;
    end else if (core_ce) begin
      rq_s1_q <= req_tgl_q;
      rq_s2_q <= rq_s1_q;
      rq_s3_q <= rq_s2_q;
      start_q <= (rq_s2_q != rq_s3_q);
      if (rq_s2_q != rq_s3_q) begin
        start_ch_q <= req_ch_q;
      end
    end
  end

  // Converter results wait here; a full buffer pushes back on conv_ready
  adcsp_fifo #(
    .WIDTH (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (core_clk),
    .reset     (reset),
    .ce        (core_ce),
    .in_valid  (conv_valid),
    .in_ready  (conv_ready),
    .in_data   (conv_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  assign fifo_pop = (xf_state_q == XF_IDLE) && fifo_valid;

  // Acknowledge synchroniser; the link only answers while its clock runs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else if (core_ce) begin
      ack_s1_q <= xf_s3_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  // One word in flight; data is held steady until the link has taken it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      xf_state_q  <= XF_IDLE;
      xfer_tgl_q  <= 1'b0;
      xfer_data_q <= '0;
    end else if (core_ce) begin
      unique case (xf_state_q)
        XF_IDLE: begin
          if (fifo_valid) begin
            xfer_data_q <= fifo_data;
            xfer_tgl_q  <= !xfer_tgl_q;
            xf_state_q  <= XF_WAIT;
          end
        end
        XF_WAIT: begin
          if (ack_s2_q == xfer_tgl_q) begin
            xf_state_q <= XF_IDLE;
          end
        end
      endcase
    end
  end

  // Bit as it stood at each rising edge; the launch check compares it at the next fall
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      sdo_rise_q <= 1'b0;
    end else begin
      sdo_rise_q <= sdo_q;
    end
  end

  // Checks on the link and core sides
  a_track_three: assert property (@(negedge sclk) disable iff (cs_n)
    (fall_idx == 5'h01) |=> !hold_q [*3] ##1 hold_q)
    else $error("track phase not three clocks");
  a_conv_thirteen: assert property (@(negedge sclk) disable iff (cs_n)
    (fall_idx == 5'h01 && hold_q) |-> (hold_len_q == 4'(CONV_CYCLES - 1)))
    else $error("hold phase not thirteen clocks");
  a_hold_edge: assert property (@(negedge sclk) disable iff (cs_n || rst_link_q)
    (req_tgl_q != $past(req_tgl_q)) |-> ($past(fall_idx) == 5'(HOLD_EDGE)) && hold_q)
    else $error("sample held on wrong falling edge");
  a_drive_frame: assert property (@(negedge sclk) disable iff (cs_n)
    sdo_oe ##1 sdo_oe)
    else $error("output not driven inside frame");
  a_release_idle: assert property (@(posedge core_clk) disable iff (reset)
    cs_n |-> !sdo_oe)
    else $error("output driven with frame select high");
  a_bit_launch: assert property (@(negedge sclk) disable iff (cs_n)
    sdo_out == sdo_rise_q)
    else $error("output bit moved on rising edge");
  a_pad_zeros: assert property (@(negedge sclk) disable iff (cs_n)
    (fall_idx < 5'(RESULT_FIRST) || fall_idx > 5'(RESULT_LAST)) |=> !sdo_out)
    else $error("pad bit not zero");
  a_result_bits: assert property (@(negedge sclk) disable iff (cs_n)
    (fall_idx >= 5'(RESULT_FIRST) && fall_idx <= 5'(RESULT_LAST)) |=>
      (sdo_out == out_word_q[4'(5'(RESULT_LAST) - $past(fall_idx))]))
    else $error("result bit out of order");
  a_chan_capture: assert property (@(posedge sclk) disable iff (cs_n || rst_link_q)
    (rise_cnt_q == CTRL_LAST_RISE) |=>
      (channel_q == {$past(sdi, 6), $past(sdi, 5), $past(sdi, 4)}))
    else $error("channel select bits misplaced");
  a_reset_chan: assert property (@(posedge core_clk)
    reset ##1 reset |-> (channel_q == CHAN_RESET))
    else $error("channel not zero after reset");
  a_start_pulse: assert property (@(posedge core_clk) disable iff (reset)
    start_q |=> !start_q)
    else $error("start pulse wider than one cycle");

  c_back_to_back: cover property (@(negedge sclk) disable iff (cs_n)
    (fall_idx == 5'h10) ##1 (fall_idx == 5'h01));
  c_new_channel: cover property (@(posedge sclk) disable iff (cs_n)
    (rise_cnt_q == CTRL_LAST_RISE) ##1 (channel_q != CHAN_RESET));
  c_fifo_full: cover property (@(posedge core_clk) disable iff (reset)
    conv_valid && !conv_ready);
endmodule
`default_nettype wire

/* File: tb/adcsp_host.sv */
`timescale 1ns/1ns
`default_nettype none
module adcsp_host
  import adcsp_pkg::*;
#(
  parameter int HALF_NS = 24 // Faster than a real host; the logic counts edges only
) (
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo_out,
  input  wire logic sdo_oe
);
  logic [7:0]  ctrl_q [16];
  logic [15:0] word_q [16];
  time         hold_t [16];
  logic        oe_on;
  logic        oe_off;

  // Clock parks high between frames so the device sees no stray edges; a short
  // select pulse at power-up gives the link's frame state a sure edge to clear on
  initial begin
    sclk = 1'b1;
    cs_n = 1'b0;
    sdi  = 1'b0;
    #1 cs_n = 1'b1;
  end

  // One frame of nconv back-to-back conversions, equal high and low phases
  task automatic frame(input int nconv);
    cs_n = 1'b0;
    #5 oe_on = sdo_oe;
    #(HALF_NS - 5);
    for (int c = 0; c < nconv; c++) begin
      for (int e = 1; e <= FRAME_CYCLES; e++) begin
        sclk = 1'b0;
        if (e == HOLD_EDGE) hold_t[c] = $time;
        // Byte goes out MSB first; the other bits toggle as junk
        if (e <= CTRL_BITS) sdi = ctrl_q[c][CTRL_BITS-e];
        else sdi = ~sdi;
        #HALF_NS sclk = 1'b1;
        word_q[c] = {word_q[c][14:0], sdo_out};
        #HALF_NS;
      end
    end
    // Released control line must not keep its last value
    cs_n = 1'b1;
    sdi  = ~sdi;
    #5 oe_off = sdo_oe;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_adc_serial_conversion_port.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_adc_serial_conversion_port;
  import adcsp_pkg::*;
  logic                core_clk;
  logic                reset;
  logic                core_ce;
  logic                conv_valid;
  logic [RESULT_W-1:0] conv_data;
  wire logic           sclk;
  wire logic           cs_n;
  wire logic           sdi;
  wire logic           sdo_out;
  wire logic           sdo_oe;
  wire logic           conv_start;
  wire logic           conv_ready;
  wire logic [CHAN_W-1:0] conv_channel;
  int                  errors;
  int                  check_count;
  int                  cycles;
  bit                  conv_auto;
  bit                  ok_auto;
  logic [2:0]          last_code;
  logic [CHAN_W-1:0]   chans [$];
  logic [RESULT_W-1:0] results [$];
  time                 start_t [$];

  adcsp_port adcsp_port_i (.core_clk(core_clk), .reset(reset), .core_ce(core_ce), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_valid(conv_valid), .conv_data(conv_data),
    .conv_ready(conv_ready));
  adcsp_host adcsp_host_i (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe));

  // Core clock; the link clock starts off its phase inside the host model
  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task check_bit(input string what, input logic exp, input logic got);
    check_val(what, {15'h0000, exp}, {15'h0000, got});
  endtask

  // Hang guard, far above the two hundred or so cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("timeout after %0d cycles", cycles);
      tally_and_finish;
    end
  end

  // Offer one word; junk on the data lines whenever valid is low
  task automatic push_word(input logic [RESULT_W-1:0] w, input int lim, output bit ok);
    ok = 0;
    #2 conv_valid = 1'b1;
    conv_data = w;
    for (int i = 0; i < lim && !ok; i++) begin
      @(posedge core_clk);
      ok = (conv_ready === 1'b1);
    end
    if (ok) results.push_back(w);
    #2 conv_valid = 1'b0;
    conv_data = ~w;
  endtask

  // Converter stand-in: while conv_auto is set, answers each start with a word that names its channel
  always @(posedge core_clk) begin
    if (conv_start === 1'b1) begin
      chans.push_back(conv_channel);
      start_t.push_back($time);
      if (conv_auto) push_word({conv_channel, 7'(results.size() * 19 + 3)}, 20, ok_auto);
    end
  end

  task wait_starts(input int n);
    for (int i = 0; i < 100 && chans.size() < n; i++) @(posedge core_clk);
    check_bit("start seen", 1'b1, chans.size() >= n);
  endtask

  // Start must follow the hold edge within the documented core latency
  task check_hold(input int k, input int c);
    time h;
    h = adcsp_host_i.hold_t[c];
    check_bit("start after hold", 1'b1, start_t[k] > h && start_t[k] <= h + 600);
  endtask

  task test_power_up;
    adcsp_host_i.ctrl_q[0] = 8'h28;
    adcsp_host_i.frame(1);
    check_bit("oe in frame", 1'b1, adcsp_host_i.oe_on);
    check_bit("oe after frame", 1'b0, adcsp_host_i.oe_off);
    wait_starts(1);
    check_val("first channel", 16'h0000, 16'(chans[0]));
    check_val("first word", 16'h0000, adcsp_host_i.word_q[0]);
    check_hold(0, 0);
    adcsp_host_i.ctrl_q[0] = 8'hd7;
    last_code = 3'h2;
    adcsp_host_i.frame(1);
    wait_starts(2);
    check_val("second channel", 16'h0005, 16'(chans[1]));
    check_val("second word", {4'h0, results[0], 2'b00}, adcsp_host_i.word_q[0]);
    $display("test_power_up done");
  endtask

  // Every channel code, back to back, with the ignored bits varied
  task test_all_codes;
    int base;
    logic [15:0] w;
    bit found;
    base = chans.size();
    for (int c = 0; c < 9; c++) adcsp_host_i.ctrl_q[c] = {2'(c), 3'(c + 1), 3'(~c)};
    adcsp_host_i.frame(9);
    wait_starts(base + 9);
    for (int c = 0; c < 9; c++) begin
      check_val("channel", 16'(c == 0 ? last_code : 3'(c)), 16'(chans[base+c]));
      check_hold(base + c, c);
      w = adcsp_host_i.word_q[c];
      check_val("padding", 16'h0000, w & 16'hf003);
      found = 0;
      foreach (results[i]) found |= (results[i] === w[11:2]);
      check_bit("result delivered", 1'b1, found);
    end
    last_code = 3'h1;
    $display("test_all_codes done");
  endtask

  // Fill the buffer with the link stalled, then drain it through a frame
  task test_fifo_fill;
    int acc;
    bit ok;
    conv_auto = 0;
    acc = 0;
    ok = 1;
    // Line the pushes up with the core clock so inputs move just after its edge
    @(posedge core_clk);
    while (ok && acc < 8) begin
      push_word(10'h3c0 + 10'(acc), 3, ok);
      if (ok) acc++;
    end
    check_bit("fill count", 1'b1, acc >= FIFO_WORDS && acc <= FIFO_WORDS + 1);
    check_bit("full refuses", 1'b0, conv_ready);
    for (int c = 0; c < 8; c++) adcsp_host_i.ctrl_q[c] = 8'h00;
    adcsp_host_i.frame(8);
    for (int i = 0; i < 50 && conv_ready !== 1'b1; i++) @(posedge core_clk);
    check_bit("drained", 1'b1, conv_ready);
    check_val("last word", {4'h0, 10'h3c0 + 10'(acc - 1), 2'b00}, adcsp_host_i.word_q[7]);
    conv_auto = 1;
    $display("test_fifo_fill done");
  endtask

  // Reset for eight cycles, then the scenarios in turn
  initial begin
    reset = 1'b1;
    core_ce = 1'b1;
    conv_valid = 1'b0;
    conv_data = 10'h2aa;
    conv_auto = 1;
    repeat (8) @(posedge core_clk);
    #2 reset = 1'b0;
    repeat (2) @(posedge core_clk);
    #7;
    test_power_up;
    test_all_codes;
    test_fifo_fill;
    tally_and_finish;
  end
endmodule
`default_nettype wire
